// ==== include/wwd_pkg.sv ====
// ****************************************************************
// Windowed watchdog constants
// ****************************************************************
package wwd_pkg;

   // Clock and oscillator rates
   localparam int CLK_FREQ_HZ  = 25000000;
   localparam int LOWPWR_OSC_HZ  = 31000;
   // Core clocks per low-power oscillator period (806)
   localparam int LOWPWR_OSC_DIV = CLK_FREQ_HZ / LOWPWR_OSC_HZ;

   // Prescaler widths: 5 bits (div 32) or 7 bits (div 128)
   localparam int PRE_SHORT_BITS = 5;
   localparam int PRE_LONG_BITS  = 7;
   localparam int POST_SEL_W     = 4;
   // Full count: 7 prescaler bits plus 15 postscaler bits
   localparam int CNT_W          = 22;

   // Register byte offsets
   localparam logic [3:0] REG_CFG  = 4'h0;
   localparam logic [3:0] REG_RSTCTL = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;

   // Configuration word one fields
   localparam int CFG_POST_LSB   = 0;
   localparam int CFG_PRESEL_BIT = 4;
   localparam int CFG_WINOFF_BIT = 6;
   localparam int CFG_HWEN_BIT   = 7;
   // Unprogrammed value: 1:32768, div 128, no window, forced on
   localparam logic [7:0] CFG_RESET = 8'hDF;

   // Reset control register fields
   localparam int RSTCTL_IDLE_BIT  = 2;
   localparam int RSTCTL_SLEEP_BIT = 3;
   localparam int RSTCTL_TO_BIT    = 4;
   localparam int RSTCTL_SWEN_BIT  = 5;

   // Status register fields
   localparam int STAT_EN_BIT    = 0;
   localparam int STAT_WIN_BIT   = 1;
   localparam int STAT_RUN_BIT   = 2;

   // Power state of the core, one-hot
   typedef enum logic [2:0]
   {
      PWR_RUN   = 3'b001,
      PWR_SLEEP = 3'b010,
      PWR_IDLE  = 3'b100
   } wwd_pwr_t;

endpackage

// ==== rtl/wwd_watchdog.sv ====
`timescale 1ns/1ps
// What this block does
// - Low-power oscillator clocks it, enabled with it
// - Config bit picks divide-by-32 or divide-by-128
// - Prescaler alone gives 1 ms or 4 ms
// - Four-bit field picks postscale 1:1 to 1:32768
// - Reset, power-save entry/exit, clear zero counts
// - Completed clock switch also zeroes counts
// - Counts in sleep/idle; time-out wakes core
// - Time-out flag sticks until software clears
// - Window mode: early clear acts as time-out
// - Window mode when window-disable bit is zero
// - Hardware enable bit forces watchdog on
// - Otherwise software enable bit switches it
// - Any device reset clears software enable
module wwd_watchdog
   import wwd_pkg::*;
#(
   parameter int OSC_DIV = LOWPWR_OSC_DIV
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        clearWdtInstr,
   input  wire logic        powerSaveInstr,
   input  wire logic        sleepSelect,
   input  wire logic        powerSaveExit,
   input  wire logic        clockSwitchDone,
   output logic             lowPowerRcOscEn,
   output logic             wdtResetReq,
   output logic             wdtWakeReq
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   generate
      if (OSC_DIV < 2)
      begin : gBadDiv
         $error("OSC_DIV must be at least 2");
      end
   endgenerate

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0]  configWordOne_q;
   logic [7:0]  configWordOne_d;
   logic        softEnable_q;
   logic        softEnable_d;
   logic        timeoutFlag_q;
   logic        timeoutFlag_d;
   logic        sleepFlag_q;
   logic        sleepFlag_d;
   logic        idleFlag_q;
   logic        idleFlag_d;
   wwd_pwr_t    pwr_q;
   wwd_pwr_t    pwr_d;
   logic [15:0] oscCnt_q;
   logic [15:0] oscCnt_d;
   logic        tick_q;
   logic        tick_d;
   logic        oscEn_q;
   logic        resetReq_q;
   logic        wake_q;
   logic        wait_q;
   logic        wait_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   logic        hwEnable;
   logic        windowDisable;
   logic        enabled;
   logic        inRun;
   logic        clrInRun;
   logic        earlyClear;
   logic        timeoutHit;
   logic        windowOpen;
   logic        fault;
   logic        wake;
   logic        enterSave;
   logic        exitSave;
   logic        counterClear;
   logic        busTake;
   logic        wrCfg;
   logic        wrRstCtl;
   logic [7:0]  rstCtlView;
   logic [7:0]  statView;
   logic        hitCfg;
   logic        hitRstCtl;
   logic        hitStat;

   // ****************************************************************
   // Enable and mode decode
   // ****************************************************************
   assign hwEnable      = configWordOne_q[CFG_HWEN_BIT];
   assign windowDisable = configWordOne_q[CFG_WINOFF_BIT];
   assign enabled       = hwEnable | softEnable_q;
   assign inRun         = (pwr_q == PWR_RUN);

   // ****************************************************************
   // Event decode
   // ****************************************************************
   // Clear instructions only count in normal execution
   assign clrInRun   = clearWdtInstr & inRun & enabled;
   // Early clear in window mode is treated as a fault
   assign earlyClear = clrInRun & ~windowDisable & ~windowOpen;
   assign fault      = (timeoutHit & inRun) | earlyClear;
   assign wake       = timeoutHit & ~inRun;
   assign enterSave  = powerSaveInstr & inRun;
   assign exitSave   = (powerSaveExit & ~inRun) | wake;
   // A disabled watchdog holds its count at zero
   assign counterClear = enterSave | exitSave | fault
                       | (clrInRun & ~earlyClear)
                       | clockSwitchDone
                       | ~enabled;

   // ****************************************************************
   // Oscillator tick, one clk pulse per oscillator period
   // ****************************************************************
   // Stopped oscillator restarts its phase from zero
   assign oscCnt_d = (~enabled || oscCnt_q == 16'(OSC_DIV - 1))
                     ? 16'h0000 : oscCnt_q + 16'h0001;
   assign tick_d   = enabled && (oscCnt_q == 16'(OSC_DIV - 1));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         oscCnt_q <= 16'h0000;
         tick_q   <= 1'b0;
         oscEn_q  <= 1'b0;
      end
      else
      begin
         oscCnt_q <= oscCnt_d;
         tick_q   <= tick_d;
         oscEn_q  <= enabled;
      end
   end

   // ****************************************************************
   // Time-out counter
   // ****************************************************************
   wwd_window_counter #(
      .CW         (CNT_W)
   ) uCounter (
      .clk        (clk),
      .rst        (rst),
      .tick       (tick_q),
      .clear      (counterClear),
      .preLong    (configWordOne_q[CFG_PRESEL_BIT]),
      .postSel    (configWordOne_q[CFG_POST_LSB +: POST_SEL_W]),
      .timeoutHit (timeoutHit),
      .windowOpen (windowOpen)
   );

   // ****************************************************************
   // Power state of the core
   // ****************************************************************
   always_comb
   begin
      pwr_d = pwr_q;
      case (pwr_q)
         PWR_RUN:
            if (enterSave)
               pwr_d = sleepSelect ? PWR_SLEEP : PWR_IDLE;
         PWR_SLEEP,
         PWR_IDLE:
            if (exitSave)
               pwr_d = PWR_RUN;
         default:
            pwr_d = PWR_RUN;
      endcase
   end

   // ****************************************************************
   // Avalon slave: one wait cycle, then a one-cycle answer
   // ****************************************************************
   assign busTake = (avs_read | avs_write) & ~wait_q;
   assign wait_d  = ~((avs_read | avs_write) & wait_q);
   assign hitCfg  = (avs_address == REG_CFG);
   assign hitRstCtl = (avs_address == REG_RSTCTL);
   assign hitStat = (avs_address == REG_STAT);
   assign wrCfg   = busTake & avs_write & hitCfg  & avs_byteenable[0];
   assign wrRstCtl = busTake & avs_write & hitRstCtl & avs_byteenable[0];

   assign rstCtlView = {2'b00, softEnable_q, timeoutFlag_q,
                        sleepFlag_q, idleFlag_q, 2'b00};
   assign statView = {5'b00000, inRun, windowOpen, enabled};
   // Unmapped offsets read as zero
   assign rdata_d  = hitCfg    ? {24'h000000, configWordOne_q} :
                     hitRstCtl ? {24'h000000, rstCtlView} :
                     hitStat ? {24'h000000, statView} : 32'h00000000;

   // ****************************************************************
   // Register updates
   // ****************************************************************
   assign configWordOne_d = wrCfg ? avs_writedata[7:0] : configWordOne_q;
   // Watchdog reset is a device reset, so it drops software enable
   assign softEnable_d  = fault  ? 1'b0 :
                          wrRstCtl ? avs_writedata[RSTCTL_SWEN_BIT]
                                   : softEnable_q;
   // Hardware set wins over a same-cycle software clear
   assign timeoutFlag_d = timeoutHit | earlyClear |
                          (timeoutFlag_q &
                           ~(wrRstCtl & ~avs_writedata[RSTCTL_TO_BIT]));
   // Flags stay set after wake; software clears them
   assign sleepFlag_d   = (enterSave & sleepSelect) |
                          (sleepFlag_q &
                           ~(wrRstCtl & ~avs_writedata[RSTCTL_SLEEP_BIT]));
   assign idleFlag_d    = (enterSave & ~sleepSelect) |
                          (idleFlag_q &
                           ~(wrRstCtl & ~avs_writedata[RSTCTL_IDLE_BIT]));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         configWordOne_q <= CFG_RESET;
         softEnable_q    <= 1'b0;
         timeoutFlag_q   <= 1'b0;
         sleepFlag_q     <= 1'b0;
         idleFlag_q      <= 1'b0;
         pwr_q           <= PWR_RUN;
      end
      else
      begin
         configWordOne_q <= configWordOne_d;
         softEnable_q    <= softEnable_d;
         timeoutFlag_q   <= timeoutFlag_d;
         sleepFlag_q     <= sleepFlag_d;
         idleFlag_q      <= idleFlag_d;
         pwr_q           <= pwr_d;
      end
   end

   // Bus answer and event outputs
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wait_q     <= 1'b1;
         rdata_q    <= 32'h00000000;
         resetReq_q <= 1'b0;
         wake_q     <= 1'b0;
      end
      else
      begin
         wait_q     <= wait_d;
         rdata_q    <= rdata_d;
         resetReq_q <= fault;
         wake_q     <= wake;
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata    = rdata_q;
   assign lowPowerRcOscEn = oscEn_q;
   assign wdtResetReq     = resetReq_q;
   assign wdtWakeReq      = wake_q;

endmodule // wwd_watchdog

// ==== rtl/wwd_window_counter.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Combined prescaler and postscaler count
// ****************************************************************
module wwd_window_counter
   import wwd_pkg::*;
#(
   parameter int CW = CNT_W
)
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  tick,
   input  wire logic                  clear,
   input  wire logic                  preLong,
   input  wire logic [POST_SEL_W-1:0] postSel,
   output logic                       timeoutHit,
   output logic                       windowOpen
);

   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic [4:0]    shiftAmt;
   logic [CW-1:0] lastCount;
   logic [CW-1:0] windowStart;

   // Period is 2^shift ticks; one counter serves both scalers
   assign shiftAmt    = 5'(postSel) + (preLong ? 5'(PRE_LONG_BITS)
                                               : 5'(PRE_SHORT_BITS));
   assign lastCount   = ~({CW{1'b1}} << shiftAmt);
   // Three quarters of the period: top two bits of the span
   assign windowStart = lastCount ^ (lastCount >> 2);
   assign timeoutHit  = tick && (count_q == lastCount);
   assign windowOpen  = (count_q >= windowStart);

   // Clear beats the tick so a restart never skips a count
   assign count_d = clear      ? '0 :
                    timeoutHit ? '0 :
                    tick       ? count_q + 1'b1 : count_q;

   // Count register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         count_q <= '0;
      else
         count_q <= count_d;
   end

endmodule // wwd_window_counter

// ==== testbench/tb_wwd_watchdog.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin fails++; \
$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
// ***
// Watchdog bench
// ***
module tb_wwd_watchdog import wwd_pkg::*;;
   localparam int DIV = 2; // Short tick keeps periods brief
   logic        clk = 1'b0;
   logic        rst, avs_read, avs_write, go, pre;
   logic [3:0]  avs_address, post;
   logic [2:0]  op;
   logic [31:0] avs_writedata;
   logic [7:0]  rd;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest, clearWdtInstr, powerSaveInstr, sleepSelect;
   wire         powerSaveExit, clockSwitchDone, lowPowerRcOscEn;
   wire         wdtResetReq, wdtWakeReq;
   int          fails, testsRun, nRst, n, n0, e;

   wwd_watchdog #(.OSC_DIV(DIV)) u_wwd_watchdog (.clk, .rst, .avs_address,
      .avs_read, .avs_write, .avs_byteenable(4'hF), .avs_writedata,
      .avs_readdata, .avs_waitrequest, .clearWdtInstr, .powerSaveInstr,
      .sleepSelect, .powerSaveExit, .clockSwitchDone, .lowPowerRcOscEn,
      .wdtResetReq, .wdtWakeReq);
   wwd_core_model u_wwd_core_model (.clk, .rst, .go, .op, .wdtWakeReq,
      .clearWdtInstr, .powerSaveInstr, .sleepSelect, .powerSaveExit,
      .clockSwitchDone);

   // Clock, and a tally of reset requests
   initial forever #20 clk = ~clk;
   always @(posedge clk) if (wdtResetReq === 1'b1) nRst <= nRst + 1;

   // Clocks from a restart to the request
   function automatic int period(input logic p, input logic [3:0] s);
      return (1 << ((p ? 7 : 5) + s)) * DIV;
   endfunction
   // One bus cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= {24'h0, d};
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      // Idle edge so a following call never re-drives in this step
      @(posedge clk);
   endtask
   task automatic cmd(input logic [2:0] o);
      op <= o;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
   endtask
   task automatic waitReq();
      for (n = 0; wdtResetReq !== 1'b1 && wdtWakeReq !== 1'b1 && n < 3000; n++)
         @(posedge clk);
   endtask
   task automatic conclude();
      if (fails == 0 && testsRun > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Hang guard
   initial
   begin
      #2000000;
      fails++;
      conclude();
   end

   // Scenarios
   initial
   begin
      {rst, avs_read, avs_write, go, op, avs_address} = 11'h400;
      avs_writedata = 32'h0;
      n = $urandom(47793);
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(0, REG_CFG, 8'h00);
      `CHK("cfg", 8'hDF, rd)
      `CHK("oscOn", 1'b1, lowPowerRcOscEn)
      bus(0, 4'hC, 8'h00);
      `CHK("hole", 8'h00, rd)
      // Timed runs to a reset, random scaling
      repeat (4)
      begin
         pre = 1'($urandom % 2);
         post = 4'($urandom % 3);
         e = period(pre, post);
         bus(1, REG_CFG, {3'b010, pre, post});
         repeat (2) @(posedge clk);
         `CHK("oscOff", 1'b0, lowPowerRcOscEn)
         bus(1, REG_RSTCTL, 8'h20);
         waitReq();
         `CHK("period", 1'b1, n > e - 6 && n < e + 6)
         `CHK("reset", 1'b1, wdtResetReq)
         repeat (2) @(posedge clk);
         bus(0, REG_RSTCTL, 8'h00);
         `CHK("flag", 8'h10, rd)
         bus(1, REG_RSTCTL, 8'h00);
      end
      // Clears and switches hold off a short period
      bus(1, REG_CFG, 8'h40);
      bus(1, REG_RSTCTL, 8'h20);
      n0 = nRst;
      repeat (8)
      begin
         repeat (10 + $urandom % 30) @(posedge clk);
         cmd(3'($urandom % 2 * 4));
      end
      bus(1, REG_RSTCTL, 8'h00);
      `CHK("kept", n0, nRst)
      // Window: early clear faults, late clear holds
      bus(1, REG_CFG, 8'h00);
      bus(1, REG_RSTCTL, 8'h20);
      repeat (10) @(posedge clk);
      cmd(3'h0);
      repeat (4) @(posedge clk);
      `CHK("early", n0 + 1, nRst)
      bus(1, REG_RSTCTL, 8'h20);
      repeat (52) @(posedge clk);
      cmd(3'h0);
      repeat (30) @(posedge clk);
      `CHK("late", n0 + 1, nRst)
      // Sleep then idle end in a wake
      bus(1, REG_CFG, 8'h40);
      for (int k = 1; k < 3; k++)
      begin
         bus(1, REG_RSTCTL, 8'h20);
         cmd(3'(k));
         waitReq();
         `CHK("wake", 1'b1, wdtWakeReq)
         repeat (2) @(posedge clk);
         bus(0, REG_RSTCTL, 8'h00);
         `CHK("state", k == 1 ? 8'h38 : 8'h34, rd)
         bus(1, REG_RSTCTL, 8'h00);
      end
      // Leaving idle restarts the count
      bus(1, REG_RSTCTL, 8'h20);
      cmd(3'h2);
      repeat (40) @(posedge clk);
      cmd(3'h3);
      waitReq();
      `CHK("exit", 1'b1, wdtResetReq && n > 56)
      // Device reset drops the software enable
      bus(1, REG_RSTCTL, 8'h20);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(0, REG_RSTCTL, 8'h00);
      `CHK("swen", 8'h00, rd)
      conclude();
   end
endmodule // tb_wwd_watchdog

// ==== testbench/wwd_core_model.sv ====
`timescale 1ns/1ps
// ***
// Core issuing clear and power-save steps
// ***
module wwd_core_model
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic [2:0] op,
   input  wire logic       wdtWakeReq,
   output logic            clearWdtInstr,
   output logic            powerSaveInstr,
   output logic            sleepSelect,
   output logic            powerSaveExit,
   output logic            clockSwitchDone
);
   logic asleep_q;
   // A stopped core executes nothing
   wire  run  = go && !asleep_q;
   wire  save = run && (op == 3'h1 || op == 3'h2);
   // One-cycle instruction pulses
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         {asleep_q, clearWdtInstr, powerSaveInstr, sleepSelect,
          powerSaveExit, clockSwitchDone} <= 6'h0;
      else
      begin
         clearWdtInstr   <= run && op == 3'h0;
         powerSaveInstr  <= save;
         sleepSelect     <= op == 3'h1;
         powerSaveExit   <= go && asleep_q && op == 3'h3;
         clockSwitchDone <= go && op == 3'h4;
         asleep_q        <= save || (asleep_q && !wdtWakeReq
                            && !(go && op == 3'h3));
      end
   end
endmodule // wwd_core_model

// ==== testbench/wwd_watchdog_asserts.sv ====
`timescale 1ns/1ps
// ***
// Port checks
// ***
module wwd_watchdog_asserts
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        powerSaveInstr,
   input wire logic        clockSwitchDone,
   input wire logic        lowPowerRcOscEn,
   input wire logic        wdtResetReq,
   input wire logic        wdtWakeReq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // No request right after a restart
   sequence sQuiet;
      (!wdtResetReq && !wdtWakeReq) [*8];
   endsequence
   // Bus answers after one wait cycle
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("late answer");
   a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer too long");
   a_upper_zero: assert property (!avs_waitrequest
      |-> avs_readdata[31:8] == 24'h0) else $error("upper lanes set");
   a_hole_zero: assert property (!avs_waitrequest && avs_read
      && !(avs_address inside {4'h0, 4'h4, 4'h8})
      |-> avs_readdata == 32'h0) else $error("unmapped data");
   // Requests are single pulses
   a_reset_single: assert property (
      wdtResetReq |=> !wdtResetReq) else $error("long reset");
   a_wake_single: assert property (
      wdtWakeReq |-> !wdtResetReq ##1 !wdtWakeReq) else $error("bad wake");
   a_wake_osc: assert property (
      wdtWakeReq |-> $past(lowPowerRcOscEn)) else $error("wake, osc off");
   // No request for eight cycles after a save; no wake for eight cycles after a switch
   a_save_restart: assert property (
      powerSaveInstr |-> ##2 sQuiet) else $error("no restart");
   a_switch_restart: assert property (
      clockSwitchDone |-> ##2 !wdtWakeReq [*8]) else $error("no restart");
endmodule // wwd_watchdog_asserts

bind wwd_watchdog wwd_watchdog_asserts u_wwd_watchdog_asserts (.clk, .rst,
   .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
   .powerSaveInstr, .clockSwitchDone, .lowPowerRcOscEn, .wdtResetReq,
   .wdtWakeReq);
